// ### core/smi_status_enable_bank.sv
// Purpose: sticky management-irq status flags, enables and group routing
// Assumes: AXI4-Lite slave, 100 MHz aclk, pins asynchronous to aclk
// Notes: gpio enables arrive from outside on gpio_enable_mask
//
// How it works
// - status flags stay set until software writes one to the bit.
// - index 12h bits: port2 pins 0,1,2, port6 pin0, port2 pins 4-7.
// - index 13h bits: port3 pins 0-3, port4 pin1, fan, port4 pin3, port6 pin1.
// - index 14h reports port5 pins 0 to 7 in bit order.
// - index 15h reports port1 pins 0 to 7 in bit order.
// - an enable bit of one passes its source to the group irq; ring2 is passed by a zero.
// - index 16h enables parallel b1, serial2 b2, serial1 b3, floppy b4, watchdog b7.
// - index 17h bits 0-4 enable mouse, keyboard, two-wire, ring1, kbc bit; bit 5 at zero passes ring2.
// - index 17h bits 6 and 7 forward the group irq onward.
// - mouse, keyboard and the other device sources are plain levels, cleared at source.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module smi_status_enable_bank (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] gpio_p1, // port1 pins
  input wire logic [7:0] gpio_p2, // port2 pins, bit 3 unused
  input wire logic [3:0] gpio_p3, // port3 pins 0-3
  input wire logic gpio_p4_b1, // port4 pin1
  input wire logic gpio_p4_b3, // port4 pin3
  input wire logic [7:0] gpio_p5, // port5 pins
  input wire logic gpio_p6_b0, // port6 pin0
  input wire logic gpio_p6_b1, // port6 pin1
  input wire logic fan_speed_pulse_event, // fan_speed_pulse_event event pin
  input wire smi_pkg::smi_dev_irq_s dev_irq, // device irq levels
  input wire logic [31:0] gpio_enable_mask, // per-flag enables
  output logic group_mgmt_irq, // group irq, high active
  output logic mgmt_irq_pin_n, // dedicated pin, low active
  output logic serial_irq_request, // to serial irq stream
  output logic irq // block interrupt
);

  // ----------------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------------
  logic [smi_pkg::FLAG_W-1:0] pin_raw;
  logic [smi_pkg::FLAG_W-1:0] pin_s;

  // register order: p1, p5, p3/fan, p2
  assign pin_raw = {gpio_p1, gpio_p5,
                    gpio_p6_b1, gpio_p4_b3, fan_speed_pulse_event, gpio_p4_b1, gpio_p3,
                    gpio_p2[7:4], gpio_p6_b0, gpio_p2[2:0]};

  smi_sync #(.W(smi_pkg::FLAG_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_raw),
    .q(pin_s)
  );

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_ok;
  smi_pkg::smi_idx_t wr_idx;
  logic wr_byte0;

  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ok = smi_pkg::smi_addr_ok(awaddr_q);
  assign wr_idx = smi_pkg::smi_addr_idx(awaddr_q);
  assign wr_byte0 = wr_fire && wr_ok && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= smi_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? smi_pkg::RESP_OKAY : smi_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // status flags and enables
  // ----------------------------------------------------------------------
  logic [smi_pkg::FLAG_W-1:0] flag_q;
  logic [smi_pkg::FLAG_W-1:0] flag_set;
  logic [smi_pkg::FLAG_W-1:0] flag_clr;
  logic [7:0] en_dev_q;
  logic [7:0] en_route_q;

  assign flag_set = pin_s;

  // write-one-clear, one byte per status index
  always_comb begin
    flag_clr = '0;
    for (int r = 0; r < smi_pkg::STS_REGS; r++) begin
      if (wr_byte0 && (wr_idx == smi_pkg::IDX_STS_P2 + 6'(r))) begin
        flag_clr[r*8 +: 8] = wdata_q[7:0];
      end
    end
  end

  smi_sticky #(.W(smi_pkg::FLAG_W), .RST(smi_pkg::RST_FLAGS)) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(flag_set),
    .clr(flag_clr),
    .q(flag_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_dev_q <= smi_pkg::RST_EN;
    end else if (wr_byte0 && (wr_idx == smi_pkg::IDX_EN_DEV)) begin
      en_dev_q <= wdata_q[7:0] & smi_pkg::EN_DEV_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_route_q <= smi_pkg::RST_EN;
    end else if (wr_byte0 && (wr_idx == smi_pkg::IDX_EN_ROUTE)) begin
      en_route_q <= wdata_q[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // group combine and routing
  // ----------------------------------------------------------------------
  logic dev_hit;
  logic group_d;
  logic route_pin;
  logic route_serial;

  // mouse and keyboard are plain levels, cleared at source
  assign dev_hit =
    (dev_irq.parallel && en_dev_q[smi_pkg::EN1_PARALLEL]) ||
    (dev_irq.serial2 && en_dev_q[smi_pkg::EN1_SERIAL2]) ||
    (dev_irq.serial1 && en_dev_q[smi_pkg::EN1_SERIAL1]) ||
    (dev_irq.floppy && en_dev_q[smi_pkg::EN1_FLOPPY]) ||
    (dev_irq.watchdog && en_dev_q[smi_pkg::EN1_WATCHDOG]) ||
    (dev_irq.mouse && en_route_q[smi_pkg::EN2_MOUSE]) ||
    (dev_irq.keyboard && en_route_q[smi_pkg::EN2_KEYBOARD]) ||
    (dev_irq.two_wire && en_route_q[smi_pkg::EN2_TWO_WIRE]) ||
    (dev_irq.ring1 && en_route_q[smi_pkg::EN2_RING1]) ||
    (dev_irq.kbc_p12 && en_route_q[smi_pkg::EN2_KBC_P12]) ||
    (dev_irq.ring2 && !en_route_q[smi_pkg::EN2_RING2_LOW]);

  assign group_d = (|(flag_q & gpio_enable_mask)) || dev_hit;
  assign route_serial = en_route_q[smi_pkg::EN2_ROUTE_SERIAL];
  assign route_pin = en_route_q[smi_pkg::EN2_ROUTE_PIN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      group_mgmt_irq <= 1'b0;
      mgmt_irq_pin_n <= 1'b1;
      serial_irq_request <= 1'b0;
    end else begin
      group_mgmt_irq <= group_d;
      mgmt_irq_pin_n <= !(group_d && route_pin);
      serial_irq_request <= group_d && route_serial;
    end
  end

  // ----------------------------------------------------------------------
  // block interrupt
  // ----------------------------------------------------------------------
  logic [smi_pkg::EV_W-1:0] ev_q;
  logic [smi_pkg::EV_W-1:0] ev_set;
  logic [smi_pkg::EV_W-1:0] ev_clr;
  logic [smi_pkg::EV_W-1:0] ev_en_q;

  always_comb begin
    ev_set = '0;
    ev_set[smi_pkg::EV_GROUP_RISE] = group_d && !group_mgmt_irq;
    ev_set[smi_pkg::EV_FLAG_NEW] = |(flag_set & ~flag_q);
    ev_clr = '0;
    if (wr_byte0 && (wr_idx == smi_pkg::IDX_EV_CLR)) begin
      ev_clr = wdata_q[smi_pkg::EV_W-1:0];
    end
  end

  smi_sticky #(.W(smi_pkg::EV_W), .RST(smi_pkg::RST_EV)) u_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(ev_set),
    .clr(ev_clr),
    .q(ev_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_en_q <= smi_pkg::RST_EV;
    end else if (wr_byte0 && (wr_idx == smi_pkg::IDX_EV_EN)) begin
      ev_en_q <= wdata_q[smi_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_q & ev_en_q);
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;
  smi_pkg::smi_idx_t rd_idx;

  assign rd_idx = smi_pkg::smi_addr_idx(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      smi_pkg::IDX_STS_P2: rd_byte = flag_q[7:0];
      smi_pkg::IDX_STS_P3FAN: rd_byte = flag_q[15:8];
      smi_pkg::IDX_STS_P5: rd_byte = flag_q[23:16];
      smi_pkg::IDX_STS_P1: rd_byte = flag_q[31:24];
      smi_pkg::IDX_EN_DEV: rd_byte = en_dev_q;
      smi_pkg::IDX_EN_ROUTE: rd_byte = en_route_q;
      smi_pkg::IDX_EV_STS: rd_byte = {6'h00, ev_q};
      smi_pkg::IDX_EV_EN: rd_byte = {6'h00, ev_en_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= smi_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (smi_pkg::smi_addr_ok(s_axi_araddr)) begin
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= smi_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= smi_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [smi_pkg::FLAG_W-1:0] keep_v;
  logic [smi_pkg::FLAG_W-1:0] clr_only;
  assign keep_v = flag_q & ~flag_clr;
  assign clr_only = flag_clr & ~flag_set;

  property p_flag_sticky;
    |keep_v |=> ((flag_q & $past(keep_v)) == $past(keep_v));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("status flag lost");

  property p_flag_w1c;
    |clr_only |=> ((flag_q & $past(clr_only)) == '0);
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("flag not cleared");

  property p_p6b0_at_bit3;
    gpio_p6_b0 [*3] |=> flag_q[3];
  endproperty
  a_p6b0_at_bit3: assert property (p_p6b0_at_bit3) else $error("port6 pin0 misplaced");

  property p_fan_at_bit13;
    fan_speed_pulse_event [*3] |=> flag_q[13];
  endproperty
  a_fan_at_bit13: assert property (p_fan_at_bit13) else $error("fan flag misplaced");

  property p_p5b2_at_bit18;
    gpio_p5[2] [*3] |=> flag_q[18];
  endproperty
  a_p5b2_at_bit18: assert property (p_p5b2_at_bit18) else $error("port5 pin2 misplaced");

  property p_p1b7_at_bit31;
    gpio_p1[7] [*3] |=> flag_q[31];
  endproperty
  a_p1b7_at_bit31: assert property (p_p1b7_at_bit31) else $error("port1 pin7 misplaced");

  property p_disabled_blocked;
    (!(|(flag_q & gpio_enable_mask)) && !dev_hit) |=> !group_mgmt_irq;
  endproperty
  a_disabled_blocked: assert property (p_disabled_blocked) else $error("group without source");

  property p_wdt_gated;
    (dev_irq.watchdog && en_dev_q[smi_pkg::EN1_WATCHDOG]) |=> group_mgmt_irq;
  endproperty
  a_wdt_gated: assert property (p_wdt_gated) else $error("watchdog not passed");

  property p_ring2_low;
    (dev_irq.ring2 && !en_route_q[smi_pkg::EN2_RING2_LOW]) |=> group_mgmt_irq;
  endproperty
  a_ring2_low: assert property (p_ring2_low) else $error("ring2 not passed");

  property p_pin_route;
    group_d |=> (mgmt_irq_pin_n == !$past(route_pin)) &&
                (serial_irq_request == $past(route_serial));
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("group routing wrong");

  property p_idle_outputs;
    !group_d |=> mgmt_irq_pin_n && !serial_irq_request;
  endproperty
  a_idle_outputs: assert property (p_idle_outputs) else $error("route without group");

  property p_bvalid_hold;
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

  c_pin_low: cover property (group_d && route_pin ##1 !mgmt_irq_pin_n);
  c_w1c: cover property (|flag_clr);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ### core/smi_pkg.sv
// Purpose: constants, types and address helpers for the management irq bank
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: byte address of a register is four times its index
package smi_pkg;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  typedef logic [5:0] smi_idx_t;
  localparam int unsigned AXI_AW = 8;
  localparam smi_idx_t IDX_STS_P2 = 6'h12;
  localparam smi_idx_t IDX_STS_P3FAN = 6'h13;
  localparam smi_idx_t IDX_STS_P5 = 6'h14;
  localparam smi_idx_t IDX_STS_P1 = 6'h15;
  localparam smi_idx_t IDX_EN_DEV = 6'h16;
  localparam smi_idx_t IDX_EN_ROUTE = 6'h17;
  localparam smi_idx_t IDX_EV_STS = 6'h20;
  localparam smi_idx_t IDX_EV_CLR = 6'h21;
  localparam smi_idx_t IDX_EV_EN = 6'h22;

  // ----------------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------------
  localparam int unsigned STS_REGS = 4;
  localparam int unsigned FLAG_W = 32;
  localparam int unsigned EV_W = 2;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] EN_DEV_WMASK = 8'h9E;
  localparam logic [EV_W-1:0] RST_EV = 2'h0;
  localparam int unsigned EN1_PARALLEL = 1;
  localparam int unsigned EN1_SERIAL2 = 2;
  localparam int unsigned EN1_SERIAL1 = 3;
  localparam int unsigned EN1_FLOPPY = 4;
  localparam int unsigned EN1_WATCHDOG = 7;
  localparam int unsigned EN2_MOUSE = 0;
  localparam int unsigned EN2_KEYBOARD = 1;
  localparam int unsigned EN2_TWO_WIRE = 2;
  localparam int unsigned EN2_RING1 = 3;
  localparam int unsigned EN2_KBC_P12 = 4;
  localparam int unsigned EN2_RING2_LOW = 5;
  localparam int unsigned EN2_ROUTE_SERIAL = 6;
  localparam int unsigned EN2_ROUTE_PIN = 7;
  localparam int unsigned EV_GROUP_RISE = 0;
  localparam int unsigned EV_FLAG_NEW = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // on-chip device interrupt levels, cleared at their source
  typedef struct packed {
    logic parallel;
    logic serial2;
    logic serial1;
    logic floppy;
    logic watchdog;
    logic mouse;
    logic keyboard;
    logic two_wire;
    logic ring1;
    logic kbc_p12;
    logic ring2;
  } smi_dev_irq_s;

  function automatic smi_idx_t smi_addr_idx(input logic [AXI_AW-1:0] addr);
    return addr[AXI_AW-1:2];
  endfunction

  function automatic logic smi_addr_ok(input logic [AXI_AW-1:0] addr);
    smi_idx_t idx;
    idx = addr[AXI_AW-1:2];
    return (addr[1:0] == 2'h0) &&
           (((idx >= IDX_STS_P2) && (idx <= IDX_EN_ROUTE)) ||
            ((idx >= IDX_EV_STS) && (idx <= IDX_EV_EN)));
  endfunction

endpackage

// ### core/smi_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: bits are independent levels
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module smi_sync #(
  parameter int unsigned W = 8
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [W-1:0] d, // async levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### core/smi_sticky.sv
// Purpose: bank of sticky flags, set by hardware, cleared by write-one
// Assumes: set and clear are one-cycle qualified vectors
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
module smi_sticky #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [W-1:0] set, // hardware set
  input wire logic [W-1:0] clr, // software clear
  output logic [W-1:0] q // flags
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= (q & ~clr) | set;
    end
  end
endmodule
`default_nettype wire

// ### testbench/smi_host_model.sv
// Purpose: host-side receiver of the routed management irq
// Assumes: dedicated pin is push-pull, low active
// Notes: seen is a registered view of either route
`timescale 1ns/100ps
`default_nettype none
module smi_host_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic mgmt_irq_pin_n, // dedicated pin, low active
  input wire logic serial_irq_request, // serial stream request
  output logic smi_seen_q // host sees a request
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smi_seen_q <= 1'h0;
    end else begin
      smi_seen_q <= !mgmt_irq_pin_n || serial_irq_request;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_smi_status_enable_bank.sv
// Purpose: self-checking bench for the management irq bank
// Assumes: host model watches the routed outputs
// Notes: bus answers are checked against queued expectations
`timescale 1ns/100ps
`default_nettype none
module tb_smi_status_enable_bank;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, gpio_p1 = 8'h00, gpio_p2 = 8'h00, gpio_p5 = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, gpio_enable_mask = 32'h0;
  logic [3:0] gpio_p3 = 4'h0, wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic p4b1 = 1'h0, p4b3 = 1'h0, p6b0 = 1'h0, p6b1 = 1'h0, fan = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, grp, pin_n, ser, irq, seen;
  logic [1:0] bresp, rresp;
  smi_pkg::smi_dev_irq_s dev_irq = '0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] v;
  int eb[11] = '{1, 2, 3, 4, 7, 0, 1, 2, 3, 4, 5};
  localparam logic [1:0] OK = smi_pkg::RESP_OKAY;
  localparam logic [33:0] ERR = {smi_pkg::RESP_SLVERR, 32'h0};
  always #5 aclk = ~aclk;
  smi_status_enable_bank dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_p1(gpio_p1),
    .gpio_p2(gpio_p2), .gpio_p3(gpio_p3), .gpio_p4_b1(p4b1), .gpio_p4_b3(p4b3),
    .gpio_p5(gpio_p5), .gpio_p6_b0(p6b0), .gpio_p6_b1(p6b1), .fan_speed_pulse_event(fan),
    .dev_irq(dev_irq), .gpio_enable_mask(gpio_enable_mask), .group_mgmt_irq(grp),
    .mgmt_irq_pin_n(pin_n), .serial_irq_request(ser), .irq(irq));
  smi_host_model host (.aclk(aclk), .aresetn(aresetn), .mgmt_irq_pin_n(pin_n),
    .serial_irq_request(ser), .smi_seen_q(seen));
  // ----------------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [33:0] seen_v, input logic [33:0] exp_v);
    tests_run++;
    if (seen_v !== exp_v) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    $display("wrong value at %0t: bus wait ran out", $time);
    report_and_stop();
  endtask
  function automatic logic [33:0] ok(input logic [7:0] x);
    return {26'h0, x};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    if (bvalid !== 1'h1) timeout();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    if (rvalid !== 1'h1) timeout();
  endtask
  always @(posedge aclk) begin
    if (bvalid === 1'h1 && bready === 1'h1) check(34'(bresp), 34'(bq.pop_front()));
    if (rvalid === 1'h1 && rready === 1'h1) check({rresp, rdata}, rq.pop_front());
  end
  task automatic wait_n(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic pins(input int i, input logic [7:0] x);
    @(posedge aclk);
    case (i)
      0: begin
        gpio_p2 <= {x[7:4], 1'h0, x[2:0]};
        p6b0 <= x[3];
      end
      1: begin
        gpio_p3 <= x[3:0];
        p4b1 <= x[4];
        fan <= x[5];
        p4b3 <= x[6];
        p6b1 <= x[7];
      end
      2: gpio_p5 <= x;
      default: gpio_p1 <= x;
    endcase
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(50));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 6; i++) rd(8'h48 + 8'(4 * i), ok(8'h00));
    for (int i = 0; i < 3; i++) rd(8'h80 + 8'(4 * i), ok(8'h00));
    rd(8'h40, ERR);
    wr(8'h49, 8'hFF, smi_pkg::RESP_SLVERR);
    wstrb <= 4'hE;
    wr(8'h58, 8'hFF, OK);
    wstrb <= 4'hF;
    rd(8'h58, ok(8'h00));
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) | 8'h11;
      pins(i, v);
      wait_n(5);
      pins(i, 8'h00);
      wait_n(4);
      rd(8'h48 + 8'(4 * i), ok(v));
      wr(8'h48 + 8'(4 * i), 8'h0F, OK);
      rd(8'h48 + 8'(4 * i), ok(v & 8'hF0));
    end
    wr(8'h58, 8'hFF, OK);
    rd(8'h58, ok(8'h9E));
    wr(8'h5C, 8'hFF, OK);
    rd(8'h5C, ok(8'hFF));
    wr(8'h58, 8'h00, OK);
    wr(8'h5C, 8'h00, OK);
    pins(2, 8'h01);
    wait_n(5);
    pins(2, 8'h00);
    wait_n(4);
    check(34'(grp), 34'h0);
    gpio_enable_mask <= 32'h0001_0000;
    wait_n(3);
    check({32'h0, grp, pin_n}, 34'h3);
    check({32'h0, ser, seen}, 34'h0);
    wr(8'h5C, 8'h80, OK);
    wait_n(3);
    check({31'h0, pin_n, ser, seen}, 34'h1);
    wr(8'h5C, 8'h40, OK);
    wait_n(3);
    check({31'h0, pin_n, ser, seen}, 34'h7);
    wr(8'h50, 8'h01, OK);
    wait_n(3);
    check({32'h0, grp, ser}, 34'h0);
    gpio_enable_mask <= 32'h0;
    for (int i = 0; i < 11; i++) begin
      wr(8'h5C, (i == 10) ? 8'h20 : 8'h00, OK);
      dev_irq <= smi_pkg::smi_dev_irq_s'(11'h400 >> i);
      wait_n(3);
      check(34'(grp), 34'h0);
      wr((i < 5) ? 8'h58 : 8'h5C, (i == 10) ? 8'h00 : 8'(1 << eb[i]), OK);
      wait_n(3);
      check(34'(grp), 34'h1);
      dev_irq <= '0;
      wr(8'h58, 8'h00, OK);
    end
    wr(8'h84, 8'h03, OK);
    wr(8'h88, 8'h01, OK);
    wr(8'h58, 8'h02, OK);
    dev_irq <= smi_pkg::smi_dev_irq_s'(11'h400);
    wait_n(5);
    check(34'(irq), 34'h1);
    rd(8'h80, ok(8'h01));
    wr(8'h84, 8'h01, OK);
    wait_n(3);
    check(34'(irq), 34'h0);
    dev_irq <= '0;
    wr(8'h88, 8'h00, OK);
    dev_irq <= smi_pkg::smi_dev_irq_s'(11'h400);
    wait_n(5);
    check(34'(irq), 34'h0);
    wr(8'h80, 8'h01, OK);
    rd(8'h80, ok(8'h01));
    report_and_stop();
  end
endmodule
`default_nettype wire
